// *** dv/jbd_probe.sv ***
// Purpose: board tester driving the four-wire test port
// Assumes: 800 ns test clock, idle low between frames, edges 1 ns after i_clk rises
// Notes: tdo read as unknown while output enable is low
`default_nettype none
module jbd_probe (
  input wire logic i_clk,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b0;
    repeat (23) @(posedge i_clk);
    #1 o_trst_n = 1'b1;
  end
  // one test clock period is eight system clocks, so every edge keeps the same offset
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(posedge i_clk);
    #1 o_tck = 1'b1;
    tdo = i_tdo_oe ? i_tdo : 1'bx;
    repeat (4) @(posedge i_clk);
    #1 o_tck = 1'b0;
  endtask
  task automatic tlr;
    logic t;
    @(posedge i_clk);
    #1;
    for (int k = 0; k < 5; k++) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
  // idle to shift, n bits lsb first, update, idle
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
      output logic [63:0] dout);
    logic t;
    dout = 64'h0;
    @(posedge i_clk);
    #1;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], t);
      dout[k] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
endmodule // jbd_probe
`default_nettype wire

// *** dv/jbd_top_assertions.sv ***
// Purpose: port-level checks of the scan and debug port
// Assumes: bound to jbd_top, one clock domain
// Notes: tck edges are seen only through sampling, so timing checks use past samples
`default_nettype none
module jbd_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic i_system_reset_n,
  input wire logic i_bus_valid,
  input wire logic [7:0] i_core_out,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [7:0] o_pad_out,
  input wire logic o_halt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_sys_pulse;
    !i_system_reset_n ##1 i_system_reset_n [*8];
  endsequence
  sequence s_halt_set;
    !o_halt ##1 o_halt;
  endsequence
  AST_RST_OUT: assert property ($fell(i_rst) |-> !o_halt && !o_tdo_oe && o_pad_out == 8'h00)
    else $error("outputs not idle after reset");
  AST_HALT_CAUSE: assert property ($rose(o_halt) |-> $past(i_bus_valid))
    else $error("halt without a bus cycle");
  AST_HALT_HOLD: assert property (s_halt_set |=> o_halt [*4])
    else $error("halt did not hold");
  AST_HALT_FALL: assert property ($fell(o_halt) |-> !$past(i_system_reset_n, 3) ||
    !$past(i_system_reset_n, 4) || $past(i_tck, 3) || $past(i_tck, 4))
    else $error("halt cleared with no cause");
  AST_OE_FALL: assert property ($changed(o_tdo_oe) |-> !$past(i_tck, 1) && !$past(i_tck, 2))
    else $error("output enable moved off a tck fall");
  AST_TDO_FALL: assert property ($changed(o_tdo) |-> !$past(i_tck, 1) && !$past(i_tck, 3))
    else $error("tdo moved off a tck fall");
  AST_TRST_PAD: assert property (!i_trst_n [*5] |=> o_pad_out == $past(i_core_out))
    else $error("pads not functional in test reset");
  AST_SYS_NOHALT: assert property (s_sys_pulse |=> !o_halt)
    else $error("halt after system reset");
endmodule // jbd_chk
bind jbd_top jbd_chk i_jbd_chk (.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
  .i_trst_n(i_trst_n), .i_system_reset_n(i_system_reset_n), .i_bus_valid(i_bus_valid),
  .i_core_out(i_core_out), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pad_out(o_pad_out),
  .o_halt(o_halt));
`default_nettype wire

// *** dv/jbd_top_test.sv ***
// Purpose: self-checking bench of the scan and debug port
// Assumes: probe model drives the test port
// Notes: debug chain is reached through sample/preload
`default_nettype none
module jbd_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IDV = 32'h2000_4005; // arbitrary neutral id value
  logic clk = 1'b0, rst = 1'b1, srst_n = 1'b0, bv = 1'b0, bf = 1'b0, bw = 1'b0;
  logic [7:0] pin = 8'h00, core = 8'h00;
  logic [31:0] ba = 32'h0, bd = 32'h0;
  logic [63:0] r;
  wire logic tck, tms, tdi, trst_n, tdo, oe, halt;
  wire logic [7:0] pad;
  int mismatches = 0;
  int num_checks = 0;
  jbd_top #(.IDCODE(IDV)) i_jbd_top (.i_clk(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .i_system_reset_n(srst_n), .i_pin_in(pin),
    .i_core_out(core), .i_bus_valid(bv), .i_bus_fetch(bf), .i_bus_write(bw),
    .i_bus_addr(ba), .i_bus_data(bd), .o_tdo(tdo), .o_tdo_oe(oe), .o_pad_out(pad),
    .o_halt(halt));
  jbd_probe i_jbd_probe (.i_clk(clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
    .i_tdo(tdo), .i_tdo_oe(oe));
  always #50 clk = ~clk;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sc(input bit ir, input int n, input logic [63:0] d);
    i_jbd_probe.scan(ir, n, d, r);
  endtask
  task automatic dw(input logic [4:0] a, input logic [31:0] v);
    sc(1'b0, 38, {26'h0, 1'b1, a, v});
  endtask
  // read: shift the index with write low, then capture and shift again
  task automatic dr(input logic [4:0] a, input logic [31:0] e);
    sc(1'b0, 38, {27'h0, a, 32'h0});
    sc(1'b0, 38, {27'h0, a, 32'h0});
    chk({32'h0, r[31:0]}, {32'h0, e});
  endtask
  task automatic st(input logic [1:0] e);
    sc(1'b0, 38, {27'h0, 5'h01, 32'h0});
    sc(1'b0, 38, {27'h0, 5'h01, 32'h0});
    chk({62'h0, r[1:0]}, {62'h0, e});
  endtask
  task automatic bus(input logic f, input logic w, input logic [31:0] a, input logic h);
    @(posedge clk) #1;
    bv = 1'b1;
    bf = f;
    bw = w;
    ba = a;
    bd = 32'h1234_56AA;
    @(posedge clk) #1;
    bv = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({63'h0, halt}, {63'h0, h});
  endtask
  task automatic t_id;
    i_jbd_probe.tlr();
    sc(1'b0, 32, 64'h0);
    chk(r, {32'h0, IDV});
    sc(1'b1, 4, 64'hE);
    chk(r, 64'h1);
    sc(1'b0, 32, 64'h0);
    chk(r, {32'h0, IDV});
    $display("test id done");
  endtask
  task automatic t_byp;
    logic [3:0] codes [4] = '{4'hF, 4'hC, 4'h5, 4'h9};
    foreach (codes[i]) begin
      sc(1'b1, 4, {60'h0, codes[i]});
      sc(1'b0, 8, 64'hB5);
      chk(r, 64'h6A);
    end
    $display("test bypass done");
  endtask
  task automatic t_bs;
    @(posedge clk) #1;
    pin = 8'hA5;
    core = 8'h3C;
    sc(1'b1, 4, 64'h3);
    sc(1'b0, 16, 64'h0);
    chk(r, 64'h3CA5);
    chk({56'h0, pad}, 64'h3C);
    sc(1'b1, 4, 64'h0);
    sc(1'b0, 16, 64'hC300);
    @(posedge clk) #1;
    chk({56'h0, pad}, 64'hC3);
    sc(1'b1, 4, 64'h2);
    sc(1'b0, 4, 64'h2);
    i_jbd_probe.tlr();
    sc(1'b1, 4, 64'h3);
    sc(1'b0, 16, 64'h0);
    chk(r, 64'h3CA5);
    $display("test boundary done");
  endtask
  task automatic t_dbg;
    sc(1'b1, 4, 64'h2);
    sc(1'b0, 4, 64'h2);
    sc(1'b1, 4, 64'h3);
    dw(5'h08, 32'h1000_0040);
    dw(5'h09, 32'h0000_000F);
    dw(5'h0B, 32'hFFFF_FFFF);
    dw(5'h0D, 32'h3);
    dw(5'h0E, 32'h3);
    dr(5'h08, 32'h1000_0040);
    bus(1'b1, 1'b0, 32'h1000_0047, 1'b0);
    dw(5'h00, 32'h1);
    st(2'b01);
    bus(1'b0, 1'b0, 32'h1000_0047, 1'b0);
    bus(1'b1, 1'b0, 32'h1000_0057, 1'b0);
    bus(1'b1, 1'b0, 32'h1000_004B, 1'b1);
    st(2'b11);
    dw(5'h00, 32'h3);
    chk({63'h0, halt}, 64'h0);
    dw(5'h10, 32'h2000_0000);
    dw(5'h11, 32'h0);
    dw(5'h12, 32'hAA);
    dw(5'h13, 32'hFFFF_FF00);
    dw(5'h14, 32'h3);
    dw(5'h15, 32'h0);
    dw(5'h16, 32'h1);
    bus(1'b0, 1'b1, 32'h2000_0000, 1'b0);
    dw(5'h14, 32'h1);
    bus(1'b0, 1'b1, 32'h2000_0000, 1'b1);
    srst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 srst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({63'h0, halt}, 64'h0);
    sc(1'b1, 4, 64'h3);
    sc(1'b0, 16, 64'h0);
    chk(r, 64'h3CA5);
    sc(1'b1, 4, 64'h2);
    sc(1'b0, 4, 64'h2);
    sc(1'b1, 4, 64'h3);
    st(2'b00);
    $display("test debug done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 srst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_id();
    t_byp();
    t_bs();
    t_dbg();
    end_of_test();
  end
  initial begin
    #3000000;
    mismatches++;
    end_of_test();
  end
endmodule // jbd_top_test
`default_nettype wire

// *** logic/jbd_cmp.v ***
// Purpose: one masked address, data and control comparator
// Assumes: bus inputs are on i_clk
// Notes: a set mask bit removes that bit from the match
`default_nettype none
`include "jbd_regs.vh"
module jbd_cmp (
  input wire [31:0] i_av,
  input wire [31:0] i_am,
  input wire [31:0] i_dv,
  input wire [31:0] i_dm,
  input wire [1:0] i_cv,
  input wire [1:0] i_cm,
  input wire [1:0] i_cfg,
  input wire i_valid,
  input wire i_fetch,
  input wire [1:0] i_ctl,
  input wire [31:0] i_addr,
  input wire [31:0] i_data,
  output wire o_match
);
  wire a_ok = ~|((i_addr ^ i_av) & ~i_am);
  wire d_ok = ~|((i_data ^ i_dv) & ~i_dm);
  wire c_ok = ~|((i_ctl ^ i_cv) & ~i_cm);
  // breakpoint watches fetches, watchpoint watches data accesses
  wire t_ok = (i_fetch == i_cfg[`JBD_CFG_BREAK]);
  assign o_match = i_cfg[`JBD_CFG_EN] & i_valid & t_ok & a_ok & d_ok & c_ok;
endmodule // jbd_cmp
`default_nettype wire

// *** logic/jbd_regs.vh ***
// Purpose: shared constants of the scan and debug port
// Assumes: included by the design files only
// Notes: debug register indices sit in a 5-bit address field
`ifndef JBD_REGS_VH
`define JBD_REGS_VH
// instruction codes
`define JBD_IR_BYPASS 4'hF
`define JBD_IR_IDCODE 4'hE
`define JBD_IR_SAMPLE 4'h3
`define JBD_IR_EXTEST 4'h0
`define JBD_IR_SCANN 4'h2
`define JBD_IR_CAPTURE 4'h1
// chain numbers
`define JBD_CHAIN_BOUNDARY 4'h3
`define JBD_CHAIN_DEBUG 4'h2
// chain lengths
`define JBD_BS_LEN 16
`define JBD_DBG_LEN 38
// debug chain fields
`define JBD_DBG_WR_BIT 37
`define JBD_DBG_ADDR_HI 36
`define JBD_DBG_ADDR_LO 32
// debug register indices
`define JBD_DA_CTRL 5'h00
`define JBD_DA_STAT 5'h01
`define JBD_DA_UNIT0 2'h1
`define JBD_DA_UNIT1 2'h2
// offsets inside one comparator unit
`define JBD_UO_AV 3'h0
`define JBD_UO_AM 3'h1
`define JBD_UO_DV 3'h2
`define JBD_UO_DM 3'h3
`define JBD_UO_CV 3'h4
`define JBD_UO_CM 3'h5
`define JBD_UO_CFG 3'h6
// control register fields
`define JBD_CTRL_EN 0
`define JBD_CTRL_CLRHALT 1
// unit config fields
`define JBD_CFG_EN 0
`define JBD_CFG_BREAK 1
`endif

// *** logic/jbd_sync.v ***
// Purpose: two flip-flop synchroniser for a W-bit group of pins
// Assumes: single clock i_clk
// Notes: stage one is read only by stage two
`default_nettype none
module jbd_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta_r;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= INIT;
      o_q <= INIT;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule // jbd_sync
`default_nettype wire

// *** logic/jbd_top.v ***
// Purpose: boundary-scan test port with chain select, id register and debug unit
// Assumes: test clock far slower than i_clk; pins synchronised here
// Notes: test clock edges are found by sampling, so TCK must stay at or under i_clk/6
// Behaviour
// - four-wire test port with standard state machine and boundary scan
// - instruction 1111 bypass, 1110 idcode, 0000 extest
// - instruction 0011 sample/preload, 0010 selects a scan chain
// - no internal test instruction; its code gets bypass
// - after chain select instruction a 4-bit chain number is shifted and latched
// - chain number 0011 selects the boundary chain
// - test-logic reset and system reset select the boundary chain
// - fixed 32-bit id: version, part number, manufacturer
// - debug unit disabled after reset until enabled
// - debug registers written serially through the test port
// - two comparator units plus a control register and a status register
// - enabled unit match on address, data, control halts the processor
// - per-bit masks drop bits from comparison
// - each unit is a watchpoint or a breakpoint
// - external watch inputs tied inactive
`default_nettype none
`include "jbd_regs.vh"
module jbd_top #(
  // arbitrary neutral value: version 1, part 0002, maker 001, lsb 1
  parameter [31:0] IDCODE = 32'h1000_2003
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_n,
  input wire i_system_reset_n,
  input wire [7:0] i_pin_in,
  input wire [7:0] i_core_out,
  input wire i_bus_valid,
  input wire i_bus_fetch,
  input wire i_bus_write,
  input wire [31:0] i_bus_addr,
  input wire [31:0] i_bus_data,
  output reg o_tdo,
  output reg o_tdo_oe,
  output reg [7:0] o_pad_out,
  output reg o_halt
);
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  // selector codes for the data path
  localparam [2:0] D_BYP = 3'h0;
  localparam [2:0] D_ID = 3'h1;
  localparam [2:0] D_SEL = 3'h2;
  localparam [2:0] D_BS = 3'h3;
  localparam [2:0] D_DBG = 3'h4;

  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_n_s;
  wire sysrst_n_s;
  wire [7:0] pin_s;
  jbd_sync #(.W(1), .INIT(1'b0)) u_s_tck (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_tck), .o_q(tck_s));
  jbd_sync #(.W(1), .INIT(1'b1)) u_s_tms (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_tms), .o_q(tms_s));
  jbd_sync #(.W(1), .INIT(1'b1)) u_s_tdi (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_tdi), .o_q(tdi_s));
  jbd_sync #(.W(1), .INIT(1'b0)) u_s_trst (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_trst_n),
    .o_q(trst_n_s));
  jbd_sync #(.W(1), .INIT(1'b0)) u_s_srst (.i_clk(i_clk), .i_rst(i_rst),
    .i_d(i_system_reset_n), .o_q(sysrst_n_s));
  jbd_sync #(.W(8), .INIT(8'h00)) u_s_pin (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_pin_in),
    .o_q(pin_s));

  reg tck_d_r;
  reg [15:0] st_r;
  reg [15:0] st_nxt;
  reg [3:0] ir_r;
  reg [3:0] ir_sh_r;
  reg [3:0] chain_r;
  reg [3:0] sel_sh_r;
  reg byp_r;
  reg [31:0] id_sh_r;
  reg [`JBD_BS_LEN-1:0] bs_sh_r;
  reg [7:0] bs_upd_r;
  reg [`JBD_DBG_LEN-1:0] dbg_sh_r;
  reg dbg_en_r;
  reg [1:0] hit_r;
  reg [31:0] u_av [0:1];
  reg [31:0] u_am [0:1];
  reg [31:0] u_dv [0:1];
  reg [31:0] u_dm [0:1];
  reg [1:0] u_cv [0:1];
  reg [1:0] u_cm [0:1];
  reg [1:0] u_cfg [0:1];
  reg [2:0] dsel;
  reg [31:0] dbg_rd;
  reg sel_bit;
  wire [1:0] match;
  wire rise = tck_s & ~tck_d_r;
  wire fall = ~tck_s & tck_d_r;
  wire sys_hold = ~sysrst_n_s;
  wire [4:0] d_addr = dbg_sh_r[`JBD_DBG_ADDR_HI:`JBD_DBG_ADDR_LO];
  wire d_unit = d_addr[4];
  wire d_in_unit = (d_addr[4:3] == `JBD_DA_UNIT0) | (d_addr[4:3] == `JBD_DA_UNIT1);
  integer k;

  // standard test port state walk on each rising test clock
  always @* begin
    st_nxt = S_TLR;
    case (st_r)
      S_TLR: st_nxt = tms_s ? S_TLR : S_RTI;
      S_RTI: st_nxt = tms_s ? S_SDS : S_RTI;
      S_SDS: st_nxt = tms_s ? S_SIS : S_CDR;
      S_CDR: st_nxt = tms_s ? S_E1DR : S_SHDR;
      S_SHDR: st_nxt = tms_s ? S_E1DR : S_SHDR;
      S_E1DR: st_nxt = tms_s ? S_UDR : S_PDR;
      S_PDR: st_nxt = tms_s ? S_E2DR : S_PDR;
      S_E2DR: st_nxt = tms_s ? S_UDR : S_SHDR;
      S_UDR: st_nxt = tms_s ? S_SDS : S_RTI;
      S_SIS: st_nxt = tms_s ? S_TLR : S_CIR;
      S_CIR: st_nxt = tms_s ? S_E1IR : S_SHIR;
      S_SHIR: st_nxt = tms_s ? S_E1IR : S_SHIR;
      S_E1IR: st_nxt = tms_s ? S_UIR : S_PIR;
      S_PIR: st_nxt = tms_s ? S_E2IR : S_PIR;
      S_E2IR: st_nxt = tms_s ? S_UIR : S_SHIR;
      S_UIR: st_nxt = tms_s ? S_SDS : S_RTI;
      default: st_nxt = S_TLR;
    endcase
  end

  // data register routing by instruction and chosen chain
  always @* begin
    case (ir_r)
      `JBD_IR_IDCODE: dsel = D_ID;
      `JBD_IR_SCANN: dsel = D_SEL;
      `JBD_IR_EXTEST, `JBD_IR_SAMPLE: begin
        if (chain_r == `JBD_CHAIN_BOUNDARY) dsel = D_BS;
        else if (chain_r == `JBD_CHAIN_DEBUG) dsel = D_DBG;
        else dsel = D_BYP;
      end
      // internal test and every other code fall to the bypass bit
      default: dsel = D_BYP;
    endcase
  end

  always @* begin
    case (dsel)
      D_ID: sel_bit = id_sh_r[0];
      D_SEL: sel_bit = sel_sh_r[0];
      D_BS: sel_bit = bs_sh_r[0];
      D_DBG: sel_bit = dbg_sh_r[0];
      default: sel_bit = byp_r;
    endcase
  end

  // read side of the debug registers, one word per index
  always @* begin
    dbg_rd = 32'h0000_0000;
    if (d_addr == `JBD_DA_CTRL) dbg_rd = {31'h0000_0000, dbg_en_r};
    else if (d_addr == `JBD_DA_STAT) dbg_rd = {28'h000_0000, hit_r, o_halt, dbg_en_r};
    else if (d_in_unit) begin
      case (d_addr[2:0])
        `JBD_UO_AV: dbg_rd = u_av[d_unit];
        `JBD_UO_AM: dbg_rd = u_am[d_unit];
        `JBD_UO_DV: dbg_rd = u_dv[d_unit];
        `JBD_UO_DM: dbg_rd = u_dm[d_unit];
        `JBD_UO_CV: dbg_rd = {30'h0000_0000, u_cv[d_unit]};
        `JBD_UO_CM: dbg_rd = {30'h0000_0000, u_cm[d_unit]};
        `JBD_UO_CFG: dbg_rd = {30'h0000_0000, u_cfg[d_unit]};
        default: dbg_rd = 32'h0000_0000;
      endcase
    end
  end

  // control bit 1 is the external watch input, wired to zero
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      jbd_cmp u_cmp (
        .i_av(u_av[g]),
        .i_am(u_am[g]),
        .i_dv(u_dv[g]),
        .i_dm(u_dm[g]),
        .i_cv(u_cv[g]),
        .i_cm(u_cm[g]),
        .i_cfg(u_cfg[g]),
        .i_valid(i_bus_valid),
        .i_fetch(i_bus_fetch),
        .i_ctl({1'b0, i_bus_write}),
        .i_addr(i_bus_addr),
        .i_data(i_bus_data),
        .o_match(match[g])
      );
    end
  endgenerate

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tck_d_r <= 1'b0;
      st_r <= S_TLR;
      ir_r <= `JBD_IR_IDCODE;
      ir_sh_r <= 4'h0;
      chain_r <= `JBD_CHAIN_BOUNDARY;
      sel_sh_r <= 4'h0;
      byp_r <= 1'b0;
      id_sh_r <= 32'h0000_0000;
      bs_sh_r <= {`JBD_BS_LEN{1'b0}};
      bs_upd_r <= 8'h00;
      dbg_sh_r <= {`JBD_DBG_LEN{1'b0}};
      dbg_en_r <= 1'b0;
      hit_r <= 2'b00;
      o_halt <= 1'b0;
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
      o_pad_out <= 8'h00;
      for (k = 0; k < 2; k = k + 1) begin
        u_av[k] <= 32'h0000_0000;
        u_am[k] <= 32'h0000_0000;
        u_dv[k] <= 32'h0000_0000;
        u_dm[k] <= 32'h0000_0000;
        u_cv[k] <= 2'b00;
        u_cm[k] <= 2'b00;
        u_cfg[k] <= 2'b00;
      end
    end else begin
      tck_d_r <= tck_s;
      if (!trst_n_s) begin
        st_r <= S_TLR;
        ir_r <= `JBD_IR_IDCODE;
      end else if (rise) begin
        st_r <= st_nxt;
        case (st_r)
          S_TLR: ir_r <= `JBD_IR_IDCODE;
          S_CIR: ir_sh_r <= `JBD_IR_CAPTURE;
          S_SHIR: ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
          S_UIR: ir_r <= ir_sh_r;
          S_CDR: begin
            byp_r <= 1'b0;
            id_sh_r <= IDCODE;
            sel_sh_r <= chain_r;
            bs_sh_r <= {i_core_out, pin_s};
            dbg_sh_r[31:0] <= dbg_rd;
          end
          S_SHDR: begin
            case (dsel)
              D_ID: id_sh_r <= {tdi_s, id_sh_r[31:1]};
              D_SEL: sel_sh_r <= {tdi_s, sel_sh_r[3:1]};
              D_BS: bs_sh_r <= {tdi_s, bs_sh_r[`JBD_BS_LEN-1:1]};
              D_DBG: dbg_sh_r <= {tdi_s, dbg_sh_r[`JBD_DBG_LEN-1:1]};
              default: byp_r <= tdi_s;
            endcase
          end
          S_UDR: begin
            if (dsel == D_SEL) chain_r <= sel_sh_r;
            if (dsel == D_BS) bs_upd_r <= bs_sh_r[`JBD_BS_LEN-1:8];
          end
          default: ;
        endcase
      end
      // test-logic reset or system reset puts the boundary chain back
      if (st_r == S_TLR || sys_hold) chain_r <= `JBD_CHAIN_BOUNDARY;
      // tdo changes on the falling test clock, as the tester samples on rising
      if (fall) begin
        o_tdo_oe <= (st_r == S_SHDR) | (st_r == S_SHIR);
        o_tdo <= (st_r == S_SHIR) ? ir_sh_r[0] : sel_bit;
      end
      // extest on the boundary chain drives the pads from the update latch, else the core drives them
      o_pad_out <= (ir_r == `JBD_IR_EXTEST && chain_r == `JBD_CHAIN_BOUNDARY) ?
        bs_upd_r : i_core_out;
      // debug register write from a completed debug chain update
      if (rise && st_r == S_UDR && dsel == D_DBG && dbg_sh_r[`JBD_DBG_WR_BIT]) begin
        if (d_addr == `JBD_DA_CTRL) dbg_en_r <= dbg_sh_r[`JBD_CTRL_EN];
        else if (d_in_unit) begin
          case (d_addr[2:0])
            `JBD_UO_AV: u_av[d_unit] <= dbg_sh_r[31:0];
            `JBD_UO_AM: u_am[d_unit] <= dbg_sh_r[31:0];
            `JBD_UO_DV: u_dv[d_unit] <= dbg_sh_r[31:0];
            `JBD_UO_DM: u_dm[d_unit] <= dbg_sh_r[31:0];
            `JBD_UO_CV: u_cv[d_unit] <= dbg_sh_r[1:0];
            `JBD_UO_CM: u_cm[d_unit] <= dbg_sh_r[1:0];
            `JBD_UO_CFG: u_cfg[d_unit] <= dbg_sh_r[1:0];
            default: ;
          endcase
        end
      end
      // hits count only while the unit is enabled; a new hit beats the clear
      hit_r <= match & {2{dbg_en_r}};
      if (dbg_en_r && |match) o_halt <= 1'b1;
      else if (rise && st_r == S_UDR && dsel == D_DBG && dbg_sh_r[`JBD_DBG_WR_BIT] &&
          d_addr == `JBD_DA_CTRL && dbg_sh_r[`JBD_CTRL_CLRHALT]) o_halt <= 1'b0;
      // system reset also powers the debug unit down
      if (sys_hold) begin
        dbg_en_r <= 1'b0;
        o_halt <= 1'b0;
      end
    end
  end
endmodule // jbd_top
`default_nettype wire
